// >>> rtl/tbc_host.sv
// Purpose: Host-side sender: serialises frame bytes and checks control characters.
// Assumes: All user inputs come from logic on clk; nothing needs synchronising.
// Notes:   Bad control characters are dropped and reported, never forwarded.
`timescale 1ns/1ps
module tbc_host (
  input  wire logic                  clk,           // 125 MHz clock
  input  wire logic                  rst_b,         // Async reset, active low
  input  wire logic                  clk_en,        // Freezes all state while low
  // Frame byte stream in
  input  wire logic                  fr_valid,      // Byte offered
  input  wire logic [7:0]            fr_data,       // Byte value
  input  wire logic                  fr_first,      // Byte zero of a frame
  input  wire logic                  fr_last,       // Last byte of a frame
  input  wire logic                  fr_msb_val,    // Byte holds a value, MSb in bit 7
  input  wire logic [7:0]            fr_rsv_mask,   // Ones mark reserved bits
  output logic                       fr_ready,      // Byte taken when high with valid
  // Serial link out
  output logic                       ser_bit,       // Serial data bit
  output logic                       ser_valid,     // Bit is meaningful
  output logic                       ser_sof,       // First bit of frame byte zero
  output logic                       ser_eof,       // Last bit of the frame's last byte
  output logic                       frame_err,     // Pulse: framing markers misused
  // Control message characters in
  input  wire logic                  ctl_valid,     // Character offered
  input  wire logic [7:0]            ctl_char,      // Character value
  input  wire tbc_pkg::tbc_kind_type ctl_kind,      // Claimed kind of character
  input  wire logic [3:0]            ctl_hex_width, // Digits per hex field
  output logic                       ctl_ready,     // Character taken when high
  // Checked control characters out
  output logic                       ctl_out_valid, // Pulse: character passed checks
  output logic [7:0]                 ctl_out_char,  // Passed character
  output logic                       ctl_err,       // Pulse: character refused
  output tbc_pkg::tbc_cerr_type      ctl_err_code   // Reason for the refusal
);
  import tbc_pkg::*;

  // Two independent paths share only the clock, reset and enable:
  //   - the frame serialiser turns one offered byte into eight serial bits,
  //     bit 0 first, with optional value reversal and reserved-bit clearing;
  //   - the character checker passes or refuses one control character per
  //     cycle, two enabled edges after it is taken.
  // Nothing here buffers: a byte is held only in the shifter, and a
  // character only in the single front stage, so back pressure on the frame
  // side comes straight from the serialiser being busy.
  // Dropping clk_en freezes every register, outputs included, so a pulse
  // that was high when the enable fell stays high until it returns.

  // ---------------------------------------------------------------------
  // Frame serialiser
  // ---------------------------------------------------------------------
  // Serialiser state: shifter, bit counter, the markers of the byte on the
  // wire, and whether a frame is open; in_frame_reg lets misuse of the
  // first and last markers be seen without counting bytes
  tbc_ser_type state_reg;
  tbc_ser_type state_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [2:0]  bit_reg;
  logic [2:0]  bit_next;
  logic        first_reg;
  logic        last_reg;
  logic        in_frame_reg;
  logic        in_frame_next;
  logic        ready_reg;
  logic        ser_bit_reg;
  logic        ser_valid_reg;
  logic        ser_sof_reg;
  logic        ser_eof_reg;
  logic        frame_err_reg;

  // Byte accept: one byte at a time, so bytes leave in the order given
  wire        take_byte = ready_reg && fr_valid;
  wire        bit_done  = (state_reg == SS_SHIFT) && (bit_reg == BIT_LAST);

  // Value bytes are bit-reversed so their MSb lands in bit 0
  wire [7:0]  rev_data;
  genvar gi;
  generate
    for (gi = 0; gi < BYTE_W; gi++) begin : g_rev
      assign rev_data[gi] = fr_data[BYTE_W-1-gi];
    end
  endgenerate
  // Plain bytes go out as given; value bytes go out MSb first
  wire [7:0]  ord_data  = fr_msb_val ? rev_data : fr_data;
  // Reserved positions are cleared after ordering, so the mask is in link order
  wire [7:0]  load_data = ord_data & ~fr_rsv_mask;

  // A new frame may not open inside an open one, and a byte must not float
  // outside a frame; either misuse is reported but the byte still goes out
  wire        bad_first = take_byte && fr_first && in_frame_reg;
  wire        bad_orph  = take_byte && !fr_first && !in_frame_reg;

  // A take always reloads the shifter; it can only happen in IDLE because
  // ready is low for the whole of SHIFT, so no byte can be cut short
  // Next-state decode
  always_comb begin
    state_next    = state_reg;
    shift_next    = shift_reg;
    bit_next      = bit_reg;
    in_frame_next = in_frame_reg;
    if (take_byte) begin
      state_next    = SS_SHIFT;
      shift_next    = load_data;
      bit_next      = BIT_FIRST;
      in_frame_next = !fr_last;
    end else if (state_reg == SS_SHIFT) begin
      // Shift right: bit 0 leaves first, bit 7 last
      shift_next = {1'b0, shift_reg[7:1]};
      bit_next   = bit_reg + 3'h1;
      if (bit_done) begin
        state_next = SS_IDLE;
      end
    end
  end

  // Reset leaves the shifter idle with no frame open
  // State and shifter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= SS_IDLE;
      shift_reg    <= CHAR_RST;
      bit_reg      <= BIT_FIRST;
      in_frame_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      bit_reg      <= bit_next;
      in_frame_reg <= in_frame_next;
    end
  end

  // Byte markers held for the whole byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else if (clk_en && take_byte) begin
      first_reg <= fr_first;
      last_reg  <= fr_last;
    end
  end

  // Ready rises only after bit 7 leaves, so a frame's last byte is fully out
  // before anything of the next one starts; costs one idle cycle per byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_reg <= 1'b0;
    end else if (clk_en) begin
      ready_reg <= (state_next == SS_IDLE) && !take_byte;
    end
  end

  // ser_bit is forced low outside SHIFT so the idle wire reads zero
  // Registered serial outputs, one cycle behind the shifter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_bit_reg   <= 1'b0;
      ser_valid_reg <= 1'b0;
      ser_sof_reg   <= 1'b0;
      ser_eof_reg   <= 1'b0;
      frame_err_reg <= 1'b0;
    end else if (clk_en) begin
      ser_bit_reg   <= (state_reg == SS_SHIFT) && shift_reg[0];
      ser_valid_reg <= (state_reg == SS_SHIFT);
      ser_sof_reg   <= (state_reg == SS_SHIFT) && first_reg && (bit_reg == BIT_FIRST);
      ser_eof_reg   <= bit_done && last_reg;
      frame_err_reg <= bad_first || bad_orph;
    end
  end

  // Top outputs are the flip-flops above, with nothing in between
  assign fr_ready  = ready_reg;
  assign ser_bit   = ser_bit_reg;
  assign ser_valid = ser_valid_reg;
  assign ser_sof   = ser_sof_reg;
  assign ser_eof   = ser_eof_reg;
  assign frame_err = frame_err_reg;

  // ---------------------------------------------------------------------
  // Control character checker
  // ---------------------------------------------------------------------
  tbc_class_if  cif ();
  tbc_char_class u_class (
    .c (cif.cls)
  );

  // Checker state: one front stage holding the taken character, trackers
  // for decimal and hex runs, and the registered verdict. The hex width is
  // read live from the input, so it must not change while a hex field is
  // open; a change mid-field moves the point where the width refusal fires.
  logic         cin_valid_reg;
  logic [7:0]   cin_char_reg;
  tbc_kind_type cin_kind_reg;
  logic         cready_reg;
  logic         dec_zero_reg;
  logic         dec_zero_next;
  logic         dec_any_reg;
  logic         dec_any_next;
  logic [3:0]   hex_cnt_reg;
  logic [3:0]   hex_cnt_next;
  logic         cout_valid_reg;
  logic [7:0]   cout_char_reg;
  logic         cerr_reg;
  tbc_cerr_type cerr_code_reg;
  tbc_cerr_type cerr_next;

  // Checker accepts one character per enabled cycle; a register stage in
  // front keeps the classifier off the user's input path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cready_reg    <= 1'b0;
      cin_valid_reg <= 1'b0;
      cin_char_reg  <= CHAR_RST;
      cin_kind_reg  <= CK_TEXT;
    end else if (clk_en) begin
      cready_reg    <= 1'b1;
      cin_valid_reg <= ctl_valid && cready_reg;
      cin_char_reg  <= ctl_char;
      cin_kind_reg  <= ctl_kind;
    end
  end

  // The classifier sees the registered character only; its flags are pure
  // decodes, so the verdict below settles within the same cycle
  assign cif.ch = cin_char_reg;

  // Field tracking: a decimal field opened by 0 must end there, and a hex
  // field must reach exactly the given width before anything else follows
  wire hex_open  = (hex_cnt_reg != HEX_CNT_RST);
  wire hex_short = hex_open && (cin_kind_reg != CK_HEX) && (hex_cnt_reg != ctl_hex_width);
  wire hex_long  = (cin_kind_reg == CK_HEX) && (hex_cnt_reg == ctl_hex_width);
  wire lead_zero = (cin_kind_reg == CK_DEC) && dec_zero_reg;

  // Character verdict; first failing check names the reason
  always_comb begin
    cerr_next = CE_NONE;
    if (cif.top_set) begin
      cerr_next = CE_TOP;
    end else if (hex_short || hex_long) begin
      cerr_next = CE_HEXW;
    end else if (lead_zero) begin
      cerr_next = CE_LZERO;
    end else begin
      case (cin_kind_reg)
        CK_SEP:  if (!cif.is_space) cerr_next = CE_SET;
        CK_END:  if (!cif.is_semi) cerr_next = CE_SET;
        CK_DEC:  if (!cif.is_dec) cerr_next = CE_SET;
        CK_HEX:  if (!cif.is_hex) cerr_next = CE_SET;
        default: if (!cif.is_g0 || cif.is_semi) cerr_next = CE_SET;
      endcase
    end
  end

  // Field state advances only on accepted characters; any other kind closes, even when refused
  always_comb begin
    dec_zero_next = dec_zero_reg;
    dec_any_next  = dec_any_reg;
    hex_cnt_next  = hex_cnt_reg;
    if (cin_valid_reg && (cerr_next == CE_NONE)) begin
      if (cin_kind_reg == CK_DEC) begin
        dec_zero_next = !dec_any_reg && (cin_char_reg == DEC_LO);
        dec_any_next  = 1'b1;
      end else begin
        dec_zero_next = 1'b0;
        dec_any_next  = 1'b0;
      end
      hex_cnt_next = (cin_kind_reg == CK_HEX) ? hex_cnt_reg + 4'h1 : HEX_CNT_RST;
    end else if (cin_valid_reg && (cin_kind_reg != CK_DEC) && (cin_kind_reg != CK_HEX)) begin
      // A refused closer still ends the field, so one bad field does not poison the next
      dec_zero_next = 1'b0;
      dec_any_next  = 1'b0;
      hex_cnt_next  = HEX_CNT_RST;
    end
  end

  // ctl_out_char loads every cycle, even for a refused character; only the
  // valid pulse says whether it may be used
  // Field state and verdict outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_zero_reg   <= 1'b0;
      dec_any_reg    <= 1'b0;
      hex_cnt_reg    <= HEX_CNT_RST;
      cout_valid_reg <= 1'b0;
      cout_char_reg  <= CHAR_RST;
      cerr_reg       <= 1'b0;
      cerr_code_reg  <= CE_NONE;
    end else if (clk_en) begin
      dec_zero_reg   <= dec_zero_next;
      dec_any_reg    <= dec_any_next;
      hex_cnt_reg    <= hex_cnt_next;
      cout_valid_reg <= cin_valid_reg && (cerr_next == CE_NONE);
      cout_char_reg  <= cin_char_reg;
      cerr_reg       <= cin_valid_reg && (cerr_next != CE_NONE);
      cerr_code_reg  <= cin_valid_reg ? cerr_next : CE_NONE;
    end
  end

  // Checker outputs come straight from flip-flops: ctl_ready from the front stage, the rest from the verdict
  assign ctl_ready     = cready_reg;
  assign ctl_out_valid = cout_valid_reg;
  assign ctl_out_char  = cout_char_reg;
  assign ctl_err       = cerr_reg;
  assign ctl_err_code  = cerr_code_reg;

endmodule : tbc_host

// >>> rtl/tbc_pkg.sv
// Purpose: Shared constants and types for the transport bit-order and character host.
// Assumes: One clock domain; characters are 8-bit units of a 7-bit reference code.
// Notes:   Every fixed code, range and multi-bit reset value of the block lives here.
// Behaviour
// - Frame bytes leave in ascending byte order, byte zero first.
// - Last byte of a frame leaves before first byte of next frame.
// - Bits of each byte shift out serially, bit 0 first, bit 7 last.
// - Data values sit MSb in bit 0, so receiver sees MSb first.
// - Reserved bits are driven as zero unless a field defines otherwise.
// - Control characters are 8-bit units whose top bit is zero.
// - Space appears only as separator between data fields.
// - Only printable codes 2/1 to 7/14; semicolon only terminates a message.
// - Decimal fields use digits 3/0 to 3/9 without a leading zero.
// - Hex fields use 3/0-3/9 and 4/1-4/6, zero-padded to full width.
package tbc_pkg;

  localparam int unsigned BYTE_W       = 8;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  BIT_FIRST    = 3'h0;
  localparam logic [7:0]  CHAR_SPACE   = 8'h20;
  localparam logic [7:0]  CHAR_SEMI    = 8'h3B;
  localparam logic [7:0]  G0_LO        = 8'h21;
  localparam logic [7:0]  G0_HI        = 8'h7E;
  localparam logic [7:0]  DEC_LO       = 8'h30;
  localparam logic [7:0]  DEC_HI       = 8'h39;
  localparam logic [7:0]  HEXL_LO      = 8'h41;
  localparam logic [7:0]  HEXL_HI      = 8'h46;
  localparam logic [7:0]  CHAR_RST     = 8'h00;
  localparam logic [3:0]  HEX_CNT_RST  = 4'h0;

  // Kind of character the user claims to be sending
  typedef enum logic [2:0] {
    CK_TEXT = 3'b000,
    CK_SEP  = 3'b001,
    CK_DEC  = 3'b010,
    CK_HEX  = 3'b011,
    CK_END  = 3'b100
  } tbc_kind_type;

  // Error codes reported with a refused character
  typedef enum logic [2:0] {
    CE_NONE  = 3'b000,
    CE_TOP   = 3'b001,
    CE_SET   = 3'b010,
    CE_LZERO = 3'b011,
    CE_HEXW  = 3'b100
  } tbc_cerr_type;

  // Serialiser states
  typedef enum logic [1:0] {
    SS_IDLE  = 2'b00,
    SS_SHIFT = 2'b01
  } tbc_ser_type;

endpackage : tbc_pkg

// >>> rtl/tbc_class_if.sv
// Purpose: Carries one character and its class flags between classifier and host.
// Assumes: Purely combinational contents.
// Notes:   Classifier drives flags, host drives the character.
`timescale 1ns/1ps
interface tbc_class_if;
  logic [7:0] ch;        // Character under test
  logic       top_set;   // Top bit is one
  logic       is_space;  // Space code
  logic       is_semi;   // Message terminator
  logic       is_g0;     // Printable code 2/1..7/14
  logic       is_dec;    // Decimal digit
  logic       is_hex;    // Hex digit, upper case only
  modport host (output ch, input top_set, is_space, is_semi, is_g0, is_dec, is_hex);
  modport cls  (input ch, output top_set, is_space, is_semi, is_g0, is_dec, is_hex);
endinterface : tbc_class_if

// >>> rtl/tbc_char_class.sv
// Purpose: Classifies one control-message character into the permitted subsets.
// Assumes: Character arrives already registered on the host side.
// Notes:   No state; flags are pure decodes of the byte.
`timescale 1ns/1ps
module tbc_char_class (
  tbc_class_if.cls c   // Character in, class flags out
);
  import tbc_pkg::*;

  // Range decodes; top bit set keeps every printable class false
  assign c.top_set  = c.ch[7];
  assign c.is_space = (c.ch == CHAR_SPACE);
  assign c.is_semi  = (c.ch == CHAR_SEMI);
  assign c.is_g0    = (c.ch >= G0_LO) && (c.ch <= G0_HI);
  assign c.is_dec   = (c.ch >= DEC_LO) && (c.ch <= DEC_HI);
  assign c.is_hex   = c.is_dec || ((c.ch >= HEXL_LO) && (c.ch <= HEXL_HI));
endmodule : tbc_char_class

// >>> tb/tbc_link_rx.sv
// Purpose: Far-end link receiver model: rebuilds bytes from the serial stream.
// Assumes: First bit on the wire lands in bit 0 of the rebuilt byte.
// Notes:   Sink only; it never pushes back, so it cannot hide a slow sender.
`timescale 1ns/1ps
module tbc_link_rx (
  input  wire logic  clk,        // Clock
  input  wire logic  rst_b,      // Async reset, active low
  input  wire logic  ser_bit,    // Serial bit
  input  wire logic  ser_valid,  // Bit present
  input  wire logic  ser_sof,    // Frame start marker
  input  wire logic  ser_eof,    // Frame end marker
  output logic       byte_valid, // Pulse: byte complete
  output logic [7:0] byte_data,  // Byte in wire bit order
  output logic       byte_sof,   // Byte opened a frame
  output logic       byte_eof    // Byte closed a frame
);
  logic [2:0] cnt_reg;

  // Bits land in arrival order, so any order slip shows as a wrong byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      byte_sof <= 1'b0;
      byte_eof <= 1'b0;
    end else begin
      byte_valid <= ser_valid && (cnt_reg == 3'h7);
      if (ser_valid) begin
        byte_data[cnt_reg] <= ser_bit;
        cnt_reg <= cnt_reg + 3'h1;
        if (cnt_reg == 3'h0) byte_sof <= ser_sof;
        if (cnt_reg == 3'h7) byte_eof <= ser_eof;
      end
    end
  end
endmodule : tbc_link_rx

// >>> tb/tbc_host_monitor.sv
// Purpose: Concurrent checks on the host serialiser and character checker.
// Assumes: clk_en stays high while a transfer is in flight; takes need it high.
// Notes:   Bound into tbc_host; watches only its ports.
`timescale 1ns/1ps
module tbc_host_monitor (
  input wire logic                  clk,           // Clock
  input wire logic                  rst_b,         // Async reset, active low
  input wire logic                  clk_en,        // Takes only while high
  input wire logic                  fr_valid,      // Byte offered
  input wire logic                  fr_last,       // Last byte marker
  input wire logic                  fr_ready,      // Byte taken
  input wire logic                  ser_valid,     // Bit present
  input wire logic                  ser_eof,       // Frame end marker
  input wire logic                  ctl_valid,     // Character offered
  input wire logic [7:0]            ctl_char,      // Character
  input wire tbc_pkg::tbc_kind_type ctl_kind,      // Claimed kind
  input wire logic                  ctl_ready,     // Character taken
  input wire logic                  ctl_out_valid, // Accepted pulse
  input wire logic [7:0]            ctl_out_char,  // Accepted character
  input wire logic                  ctl_err,       // Refused pulse
  input wire tbc_pkg::tbc_cerr_type ctl_err_code   // Refusal reason
);
  import tbc_pkg::*;
  // Takes on both request paths
  wire fr_take = fr_valid && fr_ready && clk_en;
  wire ct_take = ctl_valid && ctl_ready && clk_en;
  wire hex_ok = ctl_char inside {[DEC_LO:DEC_HI], [HEXL_LO:HEXL_HI]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_byte_on;
    ser_valid [*8] ##1 !ser_valid;
  endsequence
  sequence s_busy;
    !fr_ready [*7] ##1 fr_ready;
  endsequence

  property p_take_out; fr_take |-> ##2 $rose(ser_valid); endproperty
  property p_byte_len; $rose(ser_valid) |-> s_byte_on; endproperty
  property p_hold; $rose(ser_valid) |-> s_busy; endproperty
  property p_eof; fr_take && fr_last |-> ##9 ser_eof; endproperty
  property p_answer; ct_take |-> ##2 (ctl_out_valid != ctl_err); endproperty
  property p_top; ct_take && ctl_char[7] |-> ##2 ctl_err && ctl_err_code == CE_TOP; endproperty
  property p_dec;
    ct_take && ctl_kind == CK_DEC && !(ctl_char inside {[DEC_LO:DEC_HI]}) |-> ##2 ctl_err;
  endproperty
  property p_hexc; ct_take && ctl_kind == CK_HEX && !hex_ok |-> ##2 ctl_err; endproperty
  property p_sep;
    ct_take && ctl_kind == CK_SEP && ctl_char != CHAR_SPACE |-> ##2 ctl_err;
  endproperty
  property p_out;
    ctl_out_valid |-> ctl_out_char == $past(ctl_char, 2) && ctl_out_char inside {[CHAR_SPACE:G0_HI]};
  endproperty

  a_take_out: assert property (p_take_out) else $error("byte late on wire");
  a_byte_len: assert property (p_byte_len) else $error("byte not 8 bits long");
  a_hold: assert property (p_hold) else $error("ready before last bit left");
  a_eof: assert property (p_eof) else $error("end marker missing on last bit");
  a_answer: assert property (p_answer) else $error("no single answer");
  a_top: assert property (p_top) else $error("top bit set not refused");
  a_dec: assert property (p_dec) else $error("non-digit passed as decimal");
  a_hexc: assert property (p_hexc) else $error("bad hex digit passed");
  a_sep: assert property (p_sep) else $error("non-space passed as separator");
  a_out: assert property (p_out) else $error("accepted character wrong");
endmodule : tbc_host_monitor

bind tbc_host tbc_host_monitor u_tbc_host_monitor (.clk, .rst_b, .clk_en, .fr_valid, .fr_last,
  .fr_ready, .ser_valid, .ser_eof, .ctl_valid, .ctl_char, .ctl_kind, .ctl_ready, .ctl_out_valid,
  .ctl_out_char, .ctl_err, .ctl_err_code);

// >>> tb/tb.sv
// Purpose: Self-checking bench for the host serialiser and character checker.
// Assumes: clk_en high except in the freeze test; the link model rebuilds wire bytes.
// Notes:   Drivers queue expectations, one watcher compares them in order.
`timescale 1ns/1ps
module tb;
  import tbc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic fr_valid = 1'b0, fr_first = 1'b0, fr_last = 1'b0, fr_msb_val = 1'b0, ctl_valid = 1'b0;
  logic [7:0] fr_data = 8'h00, fr_rsv_mask = 8'h00, ctl_char = 8'h00;
  tbc_kind_type ctl_kind = CK_TEXT;
  logic [3:0] ctl_hex_width = 4'h2;
  logic fr_ready, ser_bit, ser_valid, ser_sof, ser_eof, frame_err, ctl_ready;
  logic ctl_out_valid, ctl_err, rx_valid, rx_sof, rx_eof;
  logic [7:0] ctl_out_char, rx_data;
  tbc_cerr_type ctl_err_code;
  logic [11:0] fq[$];
  logic [11:0] cq[$];
  int bad_count = 0, n_tests = 0, ferr_seen = 0, ferr_exp = 0;
  // Character table: value, claimed kind, expected outcome
  localparam logic [7:0] TC [23] = '{8'h41, 8'h20, 8'h31, 8'h32, 8'h20, 8'h30, 8'h35, 8'h20,
    8'h30, 8'h46, 8'h33, 8'h20, 8'h41, 8'h20, 8'h61, 8'hC1, 8'h3B, 8'h78, 8'h7F, 8'h5A, 8'h7E,
    8'h3B, 8'h41};
  localparam tbc_kind_type TK [23] = '{CK_TEXT, CK_SEP, CK_DEC, CK_DEC, CK_SEP, CK_DEC, CK_DEC,
    CK_SEP, CK_HEX, CK_HEX, CK_HEX, CK_SEP, CK_HEX, CK_SEP, CK_HEX, CK_TEXT, CK_TEXT, CK_SEP,
    CK_TEXT, CK_DEC, CK_TEXT, CK_END, CK_END};
  localparam tbc_cerr_type TE [23] = '{CE_NONE, CE_NONE, CE_NONE, CE_NONE, CE_NONE, CE_NONE,
    CE_LZERO, CE_NONE, CE_NONE, CE_NONE, CE_HEXW, CE_NONE, CE_NONE, CE_HEXW, CE_SET, CE_TOP,
    CE_SET, CE_SET, CE_SET, CE_SET, CE_NONE, CE_NONE, CE_SET};

  always #4 clk = ~clk;

  tbc_host u_tbc_host (.clk, .rst_b, .clk_en, .fr_valid, .fr_data, .fr_first, .fr_last,
    .fr_msb_val, .fr_rsv_mask, .fr_ready, .ser_bit, .ser_valid, .ser_sof, .ser_eof, .frame_err,
    .ctl_valid, .ctl_char, .ctl_kind, .ctl_hex_width, .ctl_ready, .ctl_out_valid,
    .ctl_out_char, .ctl_err, .ctl_err_code);
  tbc_link_rx u_tbc_link_rx (.clk, .rst_b, .ser_bit, .ser_valid, .ser_sof, .ser_eof,
    .byte_valid(rx_valid), .byte_data(rx_data), .byte_sof(rx_sof), .byte_eof(rx_eof));

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // A hung handshake ends the run instead of stalling it
  task automatic give_up;
    bad_count++;
    $display("MISMATCH t=%0t wait bound used up", $time);
    results();
  endtask : give_up

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction : rev8

  // Offer one byte and hold it until the take edge
  task automatic send_byte(input logic [7:0] d, input logic fst, lst, msb, input logic [7:0] msk);
    fq.push_back({2'b00, fst, lst, (msb ? rev8(d) : d) & ~msk});
    @(posedge clk);
    fr_valid <= 1'b1;
    fr_data <= d;
    fr_first <= fst;
    fr_last <= lst;
    fr_msb_val <= msb;
    fr_rsv_mask <= msk;
    for (int k = 0; k <= 40; k++) begin
      @(posedge clk);
      if (fr_ready) break;
      if (k == 40) give_up();
    end
    fr_valid <= 1'b0;
  endtask : send_byte

  // Ready stays high, so each call is a take on the next edge
  task automatic send_ch(input logic [7:0] c, input tbc_kind_type k, input tbc_cerr_type e);
    cq.push_back({e != CE_NONE, e, (e == CE_NONE) ? c : 8'h00});
    @(posedge clk);
    ctl_valid <= 1'b1;
    ctl_char <= c;
    ctl_kind <= k;
  endtask : send_ch

  // Watcher: oldest note against each result as it appears
  always @(posedge clk) begin
    if (frame_err) ferr_seen++;
    if (rx_valid && fq.size() == 0) chk(12'hFFF, 12'h000, "unexpected byte");
    else if (rx_valid) chk({2'b00, rx_sof, rx_eof, rx_data}, fq.pop_front(), "byte");
    if ((ctl_out_valid || ctl_err) && cq.size() == 0) chk(12'hFFF, 12'h000, "extra");
    else if (ctl_out_valid || ctl_err)
      chk({ctl_err, ctl_err_code, ctl_err ? 8'h00 : ctl_out_char}, cq.pop_front(),
          "char");
  end

  initial begin
    void'($urandom(26));
    repeat (4) @(posedge clk);
    chk({7'h00, fr_ready, ser_valid, ctl_ready, ctl_out_valid, ctl_err},
        12'h000, "reset");
    rst_b <= 1'b1;
    for (int k = 0; k <= 20 && !(ctl_ready && fr_ready); k++) @(posedge clk);
    chk({11'h000, ctl_ready}, 12'h001, "ready after reset");
    // Three-byte frame mixing value order and reserved masks, then a one-byte frame
    send_byte(8'($urandom), 1'b1, 1'b0, 1'b1, 8'h00);
    send_byte(8'($urandom), 1'b0, 1'b0, 1'b0, 8'hF0);
    send_byte(8'($urandom), 1'b0, 1'b1, 1'b1, 8'h81);
    send_byte(8'hA5, 1'b1, 1'b1, 1'b0, 8'h00);
    // Misused markers: a stray byte opens a frame, then two restarts land inside it
    send_byte(8'h3C, 1'b0, 1'b0, 1'b0, 8'h00);
    send_byte(8'h11, 1'b1, 1'b0, 1'b0, 8'h00);
    send_byte(8'h22, 1'b1, 1'b1, 1'b0, 8'h00);
    ferr_exp = 3;
    for (int k = 0; k <= 40 && fq.size() != 0; k++) @(posedge clk);
    if (fq.size() != 0) give_up();
    repeat (2) @(posedge clk);
    chk(12'(ferr_seen), 12'(ferr_exp), "framing errors");
    $display("Test frames done");
    // Table of codes and kinds back to back, then random printable and top-bit characters
    for (int i = 0; i < 35; i++) begin
      if (i < 23) send_ch(TC[i], TK[i], TE[i]);
      else if (i < 31) send_ch(8'($urandom_range(126, 60)), CK_TEXT, CE_NONE);
      else send_ch(8'h80 | 8'($urandom), tbc_kind_type'($urandom_range(4, 0)), CE_TOP);
    end
    @(posedge clk);
    ctl_valid <= 1'b0;
    for (int k = 0; k <= 20 && cq.size() != 0; k++) @(posedge clk);
    if (cq.size() != 0) give_up();
    $display("Test characters done");
    // Freeze: a byte and a character offered while clk_en is low must not be taken
    @(posedge clk);
    clk_en <= 1'b0;
    fr_valid <= 1'b1;
    ctl_valid <= 1'b1;
    repeat (4) @(posedge clk);
    chk({10'h000, ser_valid, ctl_out_valid | ctl_err}, 12'h000, "frozen");
    clk_en <= 1'b1;
    fr_valid <= 1'b0;
    ctl_valid <= 1'b0;
    repeat (14) @(posedge clk);
    $display("Test freeze done");
    results();
  end
endmodule : tb
